// File: rtl/adc_port_pkg.sv
package adc_port_pkg;

    // Bus and result widths.
    localparam int BUS_W = 12;
    localparam int RESULT_W = 12;

    // Mode control field positions.
    localparam int STANDBY_BIT = 0;
    localparam int CAL_BIT = 1;
    localparam int RANGE_BIT = 2;
    localparam int PIN_ROLE_BIT = 3;
    localparam int FACTORY_TEST_BIT = 9;

    // Reset value of the mode control register.
    localparam logic [11:0] MODE_RESET = 12'h000;

    // Calibration lengths in master clock cycles.
    localparam int CAL_UNI_CYCLES = 6720;
    localparam int CAL_BIP_CYCLES = 9024;

    // Resynchronisation settle length in master clock cycles.
    localparam int RESYNC_CYCLES = 16;

    // Bipolar offset applied to a straight binary sample.
    localparam logic [11:0] BIPOLAR_FLIP = 12'h800;

    // Fields of the mode control register.
    typedef struct packed {
        logic [1:0] spare_hi;
        logic factory_test;
        logic [4:0] spare_lo;
        logic pin_role;
        logic range_sel;
        logic cal_start;
        logic standby;
    } mode_ctrl_t;

    // Controller states.
    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_CAL = 3'b010,
        ST_SYNC = 3'b100
    } ctrl_state_t;

endpackage : adc_port_pkg

// File: rtl/adc_parallel_port_control.sv
`timescale 1ns/100ps
module adc_parallel_port_control #(
    parameter int WORD_PERIOD = 32,
    parameter int CAL_UNI = adc_port_pkg::CAL_UNI_CYCLES,
    parameter int CAL_BIP = adc_port_pkg::CAL_BIP_CYCLES
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Host strobes.
    input wire logic chip_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    // Shared parallel bus.
    input wire logic [11:0] bus_in,
    output logic [11:0] bus_out,
    output logic [11:0] bus_oe,
    // Dual-purpose pin.
    input wire logic dual_in,
    output logic dual_out,
    output logic dual_oe,
    // Converter side.
    input wire logic [11:0] sample_in,
    input wire logic sample_strobe,
    output logic data_ready_n,
    output logic standby
);

    localparam int CNT_W = 14;

    // Enable patterns for the shared bus; it is driven whole or not at all.
    localparam logic [11:0] BUS_DRIVE_ALL = 12'hFFF;
    localparam logic [11:0] BUS_DRIVE_NONE = 12'h000;

    // Result register contents before the first word arrives.
    localparam logic [11:0] RESULT_RESET = 12'h000;

    // True while the controller runs normally, neither calibrating nor resyncing.
    function automatic logic running(input adc_port_pkg::ctrl_state_t st);
        running = (st == adc_port_pkg::ST_RUN);
    endfunction : running

    // Registers, their next values and the counter compare results.
    adc_port_pkg::mode_ctrl_t mode_ff;
    adc_port_pkg::ctrl_state_t state_ff;
    adc_port_pkg::ctrl_state_t nxt_state;
    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic [11:0] result_ff;
    logic [11:0] bus_out_ff;
    logic [11:0] bus_oe_ff;
    logic data_ready_n_ff;
    logic data_valid_n_ff;
    logic dual_oe_ff;
    logic standby_ff;
    logic wr_prev_ff;
    logic sync_prev_ff;
    logic [CNT_W-1:0] cal_len;
    logic cal_done;
    logic sync_done;

    // Strobe decoding.
    wire read_sel = !chip_select_n && !read_strobe_n;
    wire write_sel = !chip_select_n && !write_strobe_n;
    wire write_done = wr_prev_ff && !write_sel;
    wire role_sync = mode_ff.pin_role;
    // The pin is heard only once our own driver has let go of it, so the last
    // data valid level cannot pass for a resync pulse when the role changes.
    wire pin_listen = role_sync && !dual_oe_ff;
    wire sync_edge = pin_listen && dual_in && !sync_prev_ff;
    wire cal_req = write_done && bus_in[adc_port_pkg::CAL_BIT];
    // A word offered in standby, calibration or resync is dropped, not queued.
    wire new_word = running(state_ff) && sample_strobe
        && !mode_ff.standby;
    wire [11:0] coded = mode_ff.range_sel ? (sample_in ^ adc_port_pkg::BIPOLAR_FLIP)
        : sample_in;
    // The enable lags the strobes by one cycle because it comes from a flip-flop;
    // a host should leave a cycle after a read before driving the bus itself.
    wire [11:0] nxt_bus_oe = read_sel ? BUS_DRIVE_ALL : BUS_DRIVE_NONE;

    // Calibration length follows the range bit currently held in the mode register.
    assign cal_len = mode_ff.range_sel ? CNT_W'(CAL_BIP - 1) : CNT_W'(CAL_UNI - 1);
    assign cal_done = (cnt_ff == cal_len);
    assign sync_done = (cnt_ff == CNT_W'(adc_port_pkg::RESYNC_CYCLES - 1));

    // Controller next state; resync wins over calibration and standby aborts it.
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff + CNT_W'(1);
        unique case (state_ff)
            adc_port_pkg::ST_RUN: begin
                if (sync_edge) begin
                    nxt_state = adc_port_pkg::ST_SYNC;
                    nxt_cnt = '0;
                end else if (cal_req && !bus_in[adc_port_pkg::STANDBY_BIT]) begin
                    nxt_state = adc_port_pkg::ST_CAL;
                    nxt_cnt = '0;
                end
            end
            adc_port_pkg::ST_CAL: begin
                if (sync_edge) begin
                    nxt_state = adc_port_pkg::ST_SYNC;
                    nxt_cnt = '0;
                end else if (mode_ff.standby || cal_done) begin
                    nxt_state = adc_port_pkg::ST_RUN;
                end
            end
            adc_port_pkg::ST_SYNC: begin
                if (sync_edge) begin
                    nxt_cnt = '0;
                end else if (sync_done) begin
                    nxt_state = adc_port_pkg::ST_RUN;
                end
            end
            // A code that is not one-hot falls back to normal running.
            default: begin
                nxt_state = adc_port_pkg::ST_RUN;
                nxt_cnt = '0;
            end
        endcase
    end

    // Mode control register, loaded at the end of a write strobe.
    // Loading at the release edge lets the host settle the bus during the strobe.
    // A write that meets the end of calibration wins over the self-clear,
    // so a freshly written start bit is never lost.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= adc_port_pkg::mode_ctrl_t'(adc_port_pkg::MODE_RESET);
        end else if (write_done) begin
            mode_ff <= adc_port_pkg::mode_ctrl_t'(bus_in);
        end else if (state_ff == adc_port_pkg::ST_CAL && nxt_state != adc_port_pkg::ST_CAL) begin
            mode_ff.cal_start <= 1'b0;
        end
    end

    // Controller state and counter.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= adc_port_pkg::ST_RUN;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Strobe and pin history; the pin idles high as if pulled up.
    // While the pin is ours, or in output role, the history is forced high,
    // so the first level heard afterwards cannot on its own make a rising edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_prev_ff <= 1'b0;
            sync_prev_ff <= 1'b1;
        end else begin
            wr_prev_ff <= write_sel;
            sync_prev_ff <= pin_listen ? dual_in : 1'b1;
        end
    end

    // Result register and data ready; ready is held high outside normal running.
    // Ready also rises as the controller leaves running, unless a word is taken in that same
    // cycle; such a word is announced through the first cycle of the calibration or resync.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_ff <= RESULT_RESET;
            data_ready_n_ff <= 1'b1;
            data_valid_n_ff <= 1'b1;
        end else begin
            if (new_word) begin
                result_ff <= coded;
                data_ready_n_ff <= 1'b0;
                data_valid_n_ff <= 1'b0;
            end else if (!running(state_ff) || !running(nxt_state)) begin
                data_ready_n_ff <= 1'b1;
                data_valid_n_ff <= 1'b1;
            end else if (read_sel) begin
                data_ready_n_ff <= 1'b1;
            end
        end
    end

    // Bus and pin drivers.
    // The bus comes out of reset released, and the pin starts as an input
    // until the role bit has been sampled once.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_out_ff <= RESULT_RESET;
            bus_oe_ff <= BUS_DRIVE_NONE;
            dual_oe_ff <= 1'b0;
            standby_ff <= 1'b0;
        end else begin
            bus_out_ff <= result_ff;
            bus_oe_ff <= nxt_bus_oe;
            dual_oe_ff <= !role_sync;
            standby_ff <= mode_ff.standby;
        end
    end

    // Every output comes straight from its flip-flop.
    assign bus_out = bus_out_ff;
    assign bus_oe = bus_oe_ff;
    assign dual_out = data_valid_n_ff;
    assign dual_oe = dual_oe_ff;
    assign data_ready_n = data_ready_n_ff;
    assign standby = standby_ff;

endmodule : adc_parallel_port_control

// File: test/adc_port_props.sv
`timescale 1ns/100ps
// Checks port timing of the parallel host port.
module adc_port_props #(
    parameter int CAL_UNI = 20,
    parameter int CAL_BIP = 30
) (
    // Clock, reset and host strobes.
    input logic clk, rst_n, chip_select_n, read_strobe_n, write_strobe_n,
    // Pins and converter side.
    input logic [11:0] bus_in, bus_out, bus_oe, sample_in,
    input logic dual_in, dual_out, dual_oe, sample_strobe, data_ready_n, standby
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // A write ends at the edge where the strobe pair is first released.
    sequence wr_end;
        $rose(chip_select_n | write_strobe_n);
    endsequence
    a_read_drive: assert property ((!chip_select_n && !read_strobe_n)[*2] |=> bus_oe == 12'hFFF)
        else $error("bus not driven on read");
    a_oe_whole: assert property (bus_oe == 12'h000 || bus_oe == 12'hFFF)
        else $error("partial bus drive");
    a_bus_release: assert property (read_strobe_n[*3] |-> bus_oe == 12'h000)
        else $error("bus driven without read");
    a_ready_cause: assert property ($fell(data_ready_n) |-> $past(sample_strobe))
        else $error("ready fell without a word");
    a_standby_load: assert property (wr_end |-> ##2 standby == $past(bus_in[0], 2))
        else $error("standby not loaded");
    a_pin_role: assert property (wr_end |-> ##3 dual_oe == !$past(bus_in[3], 3))
        else $error("pin role wrong");
    a_standby_quiet: assert property (standby && $past(standby) |-> !$fell(data_ready_n))
        else $error("word taken in standby");
    a_cal_hold: assert property (wr_end ##0 (bus_in[1] && !bus_in[0]) |-> ##2 data_ready_n[*8])
        else $error("ready low in calibration");
    c_word: cover property ($fell(data_ready_n));
    c_cal: cover property (wr_end ##0 bus_in[1]);
    c_sync: cover property ($rose(dual_in) && !dual_oe);
endmodule : adc_port_props

bind adc_parallel_port_control adc_port_props #(.CAL_UNI(CAL_UNI), .CAL_BIP(CAL_BIP)) u_props (
    .clk, .rst_n, .chip_select_n, .read_strobe_n, .write_strobe_n, .bus_in, .bus_out,
    .bus_oe, .sample_in, .dual_in, .dual_out, .dual_oe, .sample_strobe, .data_ready_n,
    .standby);

// File: test/adc_host_model.sv
`timescale 1ns/100ps
// Host on the parallel bus; its strobes move on falling clock edges.
module adc_host_model (
    // Clock and device outputs.
    input logic clk,
    input logic [11:0] bus_out, bus_oe,
    input logic dual_out, dual_oe,
    // Host drive.
    output logic chip_select_n, read_strobe_n, write_strobe_n,
    output logic dual_in,
    output logic [11:0] bus_in
);
    logic [11:0] hd = 12'h000;
    logic hoe = 1'b0, soe = 1'b0, slvl = 1'b1;
    // Strobes idle high until the first transfer.
    initial {chip_select_n, read_strobe_n, write_strobe_n} = 3'b111;
    // A released bus shows the inverse of the last host value.
    assign bus_in = (bus_oe & bus_out) | (~bus_oe & (hoe ? hd : ~hd));
    // Pin pulled high when nobody drives it.
    assign dual_in = dual_oe ? dual_out : (soe ? slvl : 1'b1);
    // Data stays one edge past the strobe release.
    task automatic wr(input logic [11:0] v);
        @(negedge clk);
        hd = v & 12'hDFF;
        hoe = 1'b1;
        {chip_select_n, write_strobe_n} = 2'b00;
        repeat (2) @(negedge clk);
        write_strobe_n = 1'b1;
        @(negedge clk);
        {chip_select_n, hoe} = 2'b10;
    endtask : wr
    // Read holds the strobes three cycles.
    task automatic rd(output logic [11:0] v);
        @(negedge clk);
        {chip_select_n, read_strobe_n} = 2'b00;
        repeat (3) @(negedge clk);
        v = bus_in;
        {chip_select_n, read_strobe_n} = 2'b11;
        repeat (2) @(negedge clk);
    endtask : rd
    // Low for two cycles, then a rising edge.
    task automatic sync_pulse();
        @(negedge clk);
        {soe, slvl} = 2'b10;
        repeat (2) @(negedge clk);
        slvl = 1'b1;
        @(negedge clk);
        soe = 1'b0;
    endtask : sync_pulse
endmodule : adc_host_model

// File: test/adc_parallel_port_control_tb.sv
`timescale 1ns/100ps
// Drives the port through the host model and checks results.
module adc_parallel_port_control_tb;
    logic clk, rst_n, sample_strobe;
    logic [11:0] sample_in, got, bus_in, bus_out, bus_oe;
    logic chip_select_n, read_strobe_n, write_strobe_n, dual_in, dual_out, dual_oe;
    logic data_ready_n, standby;
    int failures = 0, num_checks = 0, cyc = 0;
    always #4 clk = ~clk;
    adc_parallel_port_control #(.CAL_UNI(40), .CAL_BIP(60)) dut (.clk, .rst_n, .chip_select_n,
        .read_strobe_n, .write_strobe_n, .bus_in, .bus_out, .bus_oe, .dual_in, .dual_out,
        .dual_oe, .sample_in, .sample_strobe, .data_ready_n, .standby);
    adc_host_model host (.clk, .bus_out, .bus_oe, .dual_out, .dual_oe, .chip_select_n,
        .read_strobe_n, .write_strobe_n, .dual_in, .bus_in);
    // Compares one result.
    task automatic chk(input logic [11:0] g, input logic [11:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // Prints the verdict and ends the run.
    task automatic conclude();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    // Offers one converted word.
    task automatic smp(input logic [11:0] v);
        @(negedge clk);
        {sample_in, sample_strobe} = {v, 1'b1};
        @(negedge clk);
        sample_strobe = 1'b0;
        @(negedge clk);
    endtask : smp
    // Cuts a hang short.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            conclude();
        end
    end
    // Main sequence.
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        sample_strobe = 1'b0;
        sample_in = 12'h000;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        chk({9'h000, data_ready_n, standby, bus_oe[0]}, 12'h004);
        smp(12'hA5C);
        chk({11'h000, data_ready_n}, 12'h000);
        chk({11'h000, dual_out}, 12'h000);
        host.rd(got);
        chk(got, 12'hA5C);
        host.wr(12'h004);
        chk({11'h000, dual_oe}, 12'h001);
        smp(12'h123);
        host.rd(got);
        chk(got, 12'h923);
        host.wr(12'h006);
        smp(12'h111);
        chk({10'h000, dual_out, data_ready_n}, 12'h003);
        repeat (60) @(negedge clk);
        smp(12'h0F0);
        host.rd(got);
        chk(got, 12'h8F0);
        host.wr(12'h002);
        host.wr(12'h003);
        smp(12'h222);
        chk({10'h000, standby, data_ready_n}, 12'h003);
        host.wr(12'h000);
        smp(12'h3C3);
        chk({11'h000, data_ready_n}, 12'h000);
        host.wr(12'h008);
        host.wr(12'h00A);
        chk({11'h000, dual_oe}, 12'h000);
        host.sync_pulse();
        repeat (20) @(negedge clk);
        smp(12'h055);
        chk({11'h000, data_ready_n}, 12'h000);
        conclude();
    end
endmodule : adc_parallel_port_control_tb
